// ---- pfc_pkg.sv ----
// Shared constants and types for the print format code handler.
// Assumes a 7-bit character code and a paper drive that pulses once per paper step.

package pfc_pkg;

  // ************************************************************
  // Character path
  // ************************************************************
  localparam int CHAR_W = 7;                   // Character code width
  localparam int FIFO_DEPTH = 16;              // Words of input buffering
  localparam int FIFO_CNT_W = 5;               // Holds 0..FIFO_DEPTH
  localparam int COL_W = 8;                    // Column pointer width
  localparam logic [7:0] LINE_CHARS = 8'h84;   // Characters per full line (132)

  // ************************************************************
  // Format control codes and printable code range
  // ************************************************************
  localparam logic [6:0] CODE_EOT = 7'h04;     // End of transmission (octal 004)
  localparam logic [6:0] CODE_LF = 7'h0a;      // Line feed (octal 012)
  localparam logic [6:0] CODE_FF = 7'h0c;      // Form feed (octal 014)
  localparam logic [6:0] CODE_CR = 7'h0d;      // Carriage return (octal 015)
  localparam logic [6:0] CODE_SP = 7'h20;      // Lowest printable code
  localparam logic [6:0] CODE_TILDE = 7'h7e;   // Highest printable code

  // ************************************************************
  // Paper travel, counted in paper steps
  // ************************************************************
  localparam int STEP_W = 16;                                  // Step counter width
  localparam logic [15:0] STEPS_PER_LINE = 16'h0010;           // One text line
  localparam logic [15:0] STEPS_PER_INCH = 16'h0060;           // One inch of paper
  localparam logic [15:0] EOT_STEPS = 16'(STEPS_PER_INCH * 8);     // 8 inches
  localparam logic [15:0] FF_ROLL_STEPS = 16'(STEPS_PER_INCH * 5 / 2); // 2-1/2 inches

  // ************************************************************
  // Sequencer states and follow-on actions
  // ************************************************************
  typedef enum logic [3:0] {
    PFC_IDLE = 4'b0001,  // Waiting for a code
    PFC_LINE = 4'b0010,  // Printing while paper moves one line
    PFC_FEED = 4'b0100,  // Fixed-distance paper travel
    PFC_TOF  = 4'b1000   // Travel to the top-of-form mark
  } pfc_state_type;

  typedef enum logic [4:0] {
    PFC_AFT_DONE = 5'b00001,  // Line feed print, nothing follows
    PFC_AFT_FULL = 5'b00010,  // Print forced by a full line buffer
    PFC_AFT_CR   = 5'b00100,  // Print caused by carriage return
    PFC_AFT_FF   = 5'b01000,  // Form feed travel follows
    PFC_AFT_EOT  = 5'b10000   // End-of-transmission travel follows
  } pfc_after_type;

endpackage : pfc_pkg

// ---- pfc_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; reset clears pointers and fill level, storage is left as is.

`timescale 1ns/1ps
`default_nettype none

module pfc_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 16,
  parameter int CNT_W = 5
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CNT_W-1:0] level
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // Storage words
  logic [PTR_W-1:0] wr_ptr;        // Next write slot
  logic [PTR_W-1:0] rd_ptr;        // Oldest word
  logic do_push;                   // Word taken in
  logic do_pop;                    // Word handed out

  assign in_ready = (level != CNT_W'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  // ************************************************************
  // Storage write
  // ************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  // ************************************************************
  // Pointers and fill level
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end
    else
    begin
      // Wrap by hand so depths that are not powers of two also work
      if (do_push)
      begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        level <= level + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        level <= level - 1'b1;
      end
    end
  end

endmodule : pfc_fifo

`default_nettype wire

// ---- pfc_handler.sv ----
// Print-mode format code handler: takes character codes from the interface
// controller, buffers them, fills the line and runs print and paper motion.
// Assumes the print engine pulses print_done once per line and the paper
// drive pulses paper_step once per step while paper_move is high.
//
// Function
// [R1] LF prints line, advances one line
// [R2] LF ignored first after full-buffer print
// [R3] LF ignored first after printing CR
// [R4] LF ignored after CR following full print
// [R5] LF drops accept until print finishes
// [R6] LF, CR, EOT reset column, clear buffer
// [R7] CR prints only with buffered characters
// [R8] CR after full-buffer print is discarded
// [R9] Repeated CR idle until new character stored
// [R10] CR drops accept until print finishes
// [R11] EOT prints, 8 inches, pump off, TOF
// [R12] EOT keeps accept low until done
// [R13] FF prints then seeks top of form
// [R14] FF beyond 8 inches stops pump
// [R15] FF keeps accept low until done
// [R16] Printing only while paper moves
// [R17] Host should send CR then LF
// [R18] Roll paper: fixed FF, EOT travel
// [R19] Host sends only while accept high

`timescale 1ns/1ps
`default_nettype none

module pfc_handler (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic char_valid,
  input wire logic [6:0] char_data,
  output logic accept_req,
  input wire logic paper_kind_select,
  input wire logic paper_step,
  input wire logic tof_mark,
  input wire logic print_done,
  output logic paper_move,
  output logic print_run,
  output logic toner_pump,
  output logic char_store,
  output logic [6:0] char_code,
  output logic [7:0] column,
  output logic buffer_clear
);

  // ************************************************************
  // Code classification
  // ************************************************************
  // Format codes stop the host until their action completes
  function automatic logic is_format(input logic [6:0] code);
    is_format = (code == pfc_pkg::CODE_LF) || (code == pfc_pkg::CODE_CR) ||
                (code == pfc_pkg::CODE_FF) || (code == pfc_pkg::CODE_EOT);
  endfunction : is_format

  // Codes that land in the line buffer
  function automatic logic is_print(input logic [6:0] code);
    is_print = (code >= pfc_pkg::CODE_SP) && (code <= pfc_pkg::CODE_TILDE);
  endfunction : is_print

  // ************************************************************
  // Declarations
  // ************************************************************
  pfc_pkg::pfc_state_type state;       // Sequencer state
  pfc_pkg::pfc_state_type next_state;  // Its next value
  pfc_pkg::pfc_after_type after;       // Action that follows the current phase
  pfc_pkg::pfc_after_type next_after;  // Its next value
  logic [15:0] step_cnt;               // Paper steps left or travelled
  logic [15:0] next_step_cnt;          // Its next value
  logic [7:0] col;                     // Characters in the line buffer
  logic lf_skip;                       // Next LF is swallowed
  logic full_flag;                     // Last action was a full-buffer print
  logic hold;                          // A format code is in progress
  logic next_hold;                     // Its next value
  logic seen_done;                     // Print engine finished this line
  logic finish;                        // A format code completes this cycle
  logic line_end;                      // Print phase ends this cycle
  logic pump_stop;                     // Toner pump shuts this cycle
  logic roll;                          // Roll paper selected
  logic push;                          // Character taken from host
  logic pop;                           // Entry taken from the FIFO
  logic fifo_in_ready;                 // FIFO has room
  logic fifo_valid;                    // FIFO holds an entry
  logic [6:0] fifo_data;               // Oldest FIFO entry
  logic [4:0] fifo_level;              // FIFO fill level
  logic [5:0] next_level;              // Fill level after this cycle

  assign roll = paper_kind_select;
  assign push = char_valid && accept_req;                               // [R19]
  assign pop = fifo_valid && (state == pfc_pkg::PFC_IDLE);
  assign line_end = (state == pfc_pkg::PFC_LINE) && (next_state != pfc_pkg::PFC_LINE);
  assign next_level = 6'(fifo_level) + 6'(push) - 6'(pop);

  // ************************************************************
  // Input buffer
  // ************************************************************
  // Bursts land here at full rate while a long print is running
  pfc_fifo #(
    .WIDTH(pfc_pkg::CHAR_W),
    .DEPTH(pfc_pkg::FIFO_DEPTH),
    .CNT_W(pfc_pkg::FIFO_CNT_W)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(char_data),
    .out_valid(fifo_valid),
    .out_ready(state == pfc_pkg::PFC_IDLE),
    .out_data(fifo_data),
    .level(fifo_level)
  );

  // ************************************************************
  // Sequencer next-state logic
  // ************************************************************
  always_comb
  begin
    next_state = state;
    next_after = after;
    next_step_cnt = step_cnt;
    finish = 1'b0;
    pump_stop = 1'b0;
    unique case (state)
      pfc_pkg::PFC_IDLE:
      begin
        if (pop && is_print(fifo_data) && (col == pfc_pkg::LINE_CHARS - 8'h01))
        begin
          // Last column filled, print without waiting for a code
          next_state = pfc_pkg::PFC_LINE;
          next_after = pfc_pkg::PFC_AFT_FULL;
          next_step_cnt = pfc_pkg::STEPS_PER_LINE;
        end
        else if (pop && (fifo_data == pfc_pkg::CODE_LF))
        begin
          if (lf_skip)
          begin
            finish = 1'b1;                                             // [R2] [R3] [R4]
          end
          else
          begin
            next_state = pfc_pkg::PFC_LINE;                            // [R1]
            next_after = pfc_pkg::PFC_AFT_DONE;
            next_step_cnt = pfc_pkg::STEPS_PER_LINE;
          end
        end
        else if (pop && (fifo_data == pfc_pkg::CODE_CR))
        begin
          if (full_flag || (col == 8'h00))
          begin
            finish = 1'b1;                                             // [R8] [R9]
          end
          else
          begin
            next_state = pfc_pkg::PFC_LINE;                            // [R7]
            next_after = pfc_pkg::PFC_AFT_CR;
            next_step_cnt = pfc_pkg::STEPS_PER_LINE;
          end
        end
        else if (pop && ((fifo_data == pfc_pkg::CODE_FF) ||
                         (fifo_data == pfc_pkg::CODE_EOT)))
        begin
          next_after = (fifo_data == pfc_pkg::CODE_FF) ? pfc_pkg::PFC_AFT_FF :
                                                         pfc_pkg::PFC_AFT_EOT;
          if (col != 8'h00)
          begin
            // Buffered data goes out first
            next_state = pfc_pkg::PFC_LINE;                            // [R11] [R13]
            next_step_cnt = pfc_pkg::STEPS_PER_LINE;
          end
          else if (fifo_data == pfc_pkg::CODE_EOT)
          begin
            next_state = pfc_pkg::PFC_FEED;                            // [R11]
            next_step_cnt = pfc_pkg::EOT_STEPS;
          end
          else if (roll)
          begin
            next_state = pfc_pkg::PFC_FEED;                            // [R18]
            next_step_cnt = pfc_pkg::FF_ROLL_STEPS;
          end
          else
          begin
            next_state = pfc_pkg::PFC_TOF;                             // [R13]
            next_step_cnt = 16'h0000;
          end
        end
      end
      pfc_pkg::PFC_LINE:
      begin
        if (paper_step && (step_cnt != 16'h0000))
        begin
          next_step_cnt = step_cnt - 16'h0001;
        end
        // Line is over only once paper has moved and the engine reported done
        if ((step_cnt == 16'h0000) && seen_done)
        begin
          unique case (after)
            pfc_pkg::PFC_AFT_FF:
            begin
              next_state = roll ? pfc_pkg::PFC_FEED : pfc_pkg::PFC_TOF; // [R13] [R18]
              next_step_cnt = roll ? pfc_pkg::FF_ROLL_STEPS : 16'h0000;
            end
            pfc_pkg::PFC_AFT_EOT:
            begin
              next_state = pfc_pkg::PFC_FEED;                          // [R11]
              next_step_cnt = pfc_pkg::EOT_STEPS;
            end
            pfc_pkg::PFC_AFT_FULL:
            begin
              next_state = pfc_pkg::PFC_IDLE;
            end
            default:
            begin
              next_state = pfc_pkg::PFC_IDLE;
              finish = 1'b1;                                           // [R5] [R10]
            end
          endcase
        end
      end
      pfc_pkg::PFC_FEED:
      begin
        if (paper_step)
        begin
          next_step_cnt = step_cnt - 16'h0001;
          if (step_cnt == 16'h0001)
          begin
            pump_stop = (after == pfc_pkg::PFC_AFT_EOT);               // [R11]
            if ((after == pfc_pkg::PFC_AFT_EOT) && !roll)
            begin
              next_state = pfc_pkg::PFC_TOF;                           // [R11]
              next_step_cnt = 16'h0000;
            end
            else
            begin
              next_state = pfc_pkg::PFC_IDLE;                          // [R18]
              finish = 1'b1;
            end
          end
        end
      end
      pfc_pkg::PFC_TOF:
      begin
        if (tof_mark)
        begin
          next_state = pfc_pkg::PFC_IDLE;
          finish = 1'b1;                                               // [R12] [R15]
        end
        else if (paper_step && (step_cnt != pfc_pkg::EOT_STEPS))
        begin
          next_step_cnt = step_cnt + 16'h0001;
          // Long form travel: toner would flood the idle channel
          pump_stop = (step_cnt == pfc_pkg::EOT_STEPS - 16'h0001);     // [R14]
        end
      end
    endcase
  end

  // ************************************************************
  // Sequencer registers
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= pfc_pkg::PFC_IDLE;
      after <= pfc_pkg::PFC_AFT_DONE;
      step_cnt <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      after <= next_after;
      step_cnt <= next_step_cnt;
    end
  end

  // ************************************************************
  // Print completion capture
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seen_done <= 1'b0;
    end
    else if (state != pfc_pkg::PFC_LINE)
    begin
      seen_done <= 1'b0;
    end
    else if (print_done)
    begin
      seen_done <= 1'b1;
    end
  end

  // ************************************************************
  // Duplicate spacing suppression
  // ************************************************************
  // Events that set a flag happen only at the end of a phase, while
  // clears happen on a pop in idle or at the end of any other print phase, so the two never collide.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lf_skip <= 1'b0;
      full_flag <= 1'b0;
    end
    else
    begin
      if (line_end && (after == pfc_pkg::PFC_AFT_FULL))
      begin
        lf_skip <= 1'b1;                                               // [R2]
        full_flag <= 1'b1;                                             // [R8]
      end
      else if (line_end && (after == pfc_pkg::PFC_AFT_CR))
      begin
        lf_skip <= 1'b1;                                               // [R3]
      end
      else if (line_end)
      begin
        lf_skip <= 1'b0;
        full_flag <= 1'b0;
      end
      else if (pop && (fifo_data == pfc_pkg::CODE_CR))
      begin
        // Discarded CR after a full print keeps the next LF swallowed
        lf_skip <= lf_skip || full_flag;                               // [R4]
        full_flag <= 1'b0;
      end
      else if (pop && (is_print(fifo_data) || is_format(fifo_data)))
      begin
        lf_skip <= 1'b0;
        full_flag <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Column pointer and line buffer strobes
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      col <= 8'h00;
      column <= 8'h00;
      char_store <= 1'b0;
      char_code <= 7'h00;
      buffer_clear <= 1'b0;
    end
    else
    begin
      if (line_end || finish)
      begin
        col <= 8'h00;                                                  // [R6]
        column <= 8'h00;
      end
      else if (pop && is_print(fifo_data))
      begin
        col <= col + 8'h01;
        column <= col + 8'h01;
      end
      char_store <= pop && is_print(fifo_data);
      char_code <= fifo_data;
      buffer_clear <= line_end || finish;                              // [R6]
    end
  end

  // ************************************************************
  // Host pacing
  // ************************************************************
  always_comb
  begin
    next_hold = hold;
    if (push && is_format(char_data))
    begin
      next_hold = 1'b1;                                                // [R5] [R10] [R12] [R15]
    end
    else if (finish)
    begin
      next_hold = 1'b0;
    end
  end

  // Registered ready looks one cycle ahead so the FIFO never overflows
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold <= 1'b0;
      accept_req <= 1'b0;
    end
    else
    begin
      hold <= next_hold;
      accept_req <= !next_hold && fifo_in_ready &&
                    (next_level < 6'(pfc_pkg::FIFO_DEPTH));            // [R12] [R15]
    end
  end

  // ************************************************************
  // Paper, print and toner drives
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      paper_move <= 1'b0;
      print_run <= 1'b0;
      toner_pump <= 1'b0;
    end
    else
    begin
      paper_move <= (next_state != pfc_pkg::PFC_IDLE);                 // [R16]
      // Print only inside the line phase, when paper is moving too
      print_run <= (next_state == pfc_pkg::PFC_LINE) &&
                   !((state == pfc_pkg::PFC_LINE) && (seen_done || print_done)); // [R16]
      if (next_state == pfc_pkg::PFC_LINE)
      begin
        toner_pump <= 1'b1;
      end
      else if (pump_stop)
      begin
        toner_pump <= 1'b0;                                            // [R11] [R14]
      end
    end
  end

endmodule : pfc_handler

`default_nettype wire

// ---- pfc_handler_properties.sv ----
// Port checks for the format code handler.
// Assumes binding onto pfc_handler; one clock, async reset.
`timescale 1ns/1ps
`default_nettype none
module pfc_handler_properties (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic accept_req,
  input wire logic paper_move,
  input wire logic print_run,
  input wire logic print_done,
  input wire logic toner_pump,
  input wire logic [7:0] column,
  input wire logic buffer_clear
);
  // ******
  // Checks
  // ******
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  print_while_moving_a: assert property (print_run |-> paper_move)
    else $error("print without paper motion");
  clear_zeroes_column_a: assert property (buffer_clear |-> ##[0:1] column == 8'h00)
    else $error("column not cleared");
  print_needs_data_a: assert property ($rose(print_run) |-> column != 8'h00)
    else $error("print on empty buffer");
  print_ends_done_a: assert property (print_run && print_done |=> !print_run)
    else $error("print outlasts done");
  pump_on_print_a: assert property ($rose(print_run) |-> ##[0:1] toner_pump)
    else $error("pump not on for print");
  pump_off_moving_a: assert property ($fell(toner_pump) |-> $past(paper_move))
    else $error("pump stopped without motion");
  feed_holds_accept_a: assert property (paper_move && !toner_pump |-> !accept_req)
    else $error("accept during feed");
  clear_frees_accept_a: assert property (buffer_clear && !paper_move |-> ##[0:2] (accept_req || paper_move))
    else $error("accept not back after clear");
  cover property ($rose(print_run));
  cover property ($fell(toner_pump));
  cover property (buffer_clear && !paper_move);
endmodule : pfc_handler_properties
bind pfc_handler pfc_handler_properties chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .accept_req(accept_req), .paper_move(paper_move), .print_run(print_run),
  .print_done(print_done), .toner_pump(toner_pump), .column(column),
  .buffer_clear(buffer_clear));
`default_nettype wire

// ---- pfc_host_model.sv ----
// Stand-in for the controller that sends character codes.
// Assumes accept_req is registered on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module pfc_host_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic accept_req,
  output var logic char_valid,
  output var logic [6:0] char_data
);
  // ******
  // Sender
  // ******
  initial
  begin
    char_valid = 1'b0;
    char_data = 7'h55;
  end
  // Offer one code, hold until taken; ok stays 0 on timeout
  task automatic send(input logic [6:0] c, output bit ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge clk_sys);
    while (accept_req !== 1'b1 && n < 2000)
    begin
      @(posedge clk_sys);
      n++;
    end
    char_valid <= 1'b1;
    char_data <= c;
    while (!ok && n < 2000)
    begin
      @(posedge clk_sys);
      n++;
      ok = (accept_req === 1'b1) && rst_n;
    end
    char_valid <= 1'b0;
    char_data <= ~c; // Released data never shows the last code
  endtask : send
endmodule : pfc_host_model
`default_nettype wire

// ---- test_print_format_code_handler.sv ----
// Self-checking bench for the format code handler.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module test_print_format_code_handler;
  logic clk_sys = 1'b0, rst_n = 1'b0, paper_kind_select = 1'b0;
  logic paper_step = 1'b0, tof_mark = 1'b0, print_done = 1'b0, pr_q = 1'b0;
  logic char_valid, accept_req, paper_move, print_run, toner_pump, char_store;
  logic buffer_clear, pump_tof = 1'b0;
  logic [6:0] char_data, char_code, last_code, last_sent;
  logic [7:0] column;
  int failures = 0, checked = 0, steps = 0, prints = 0, pr_cnt = 0, tof_at = -1, p0, s0;
  initial forever #4 clk_sys = ~clk_sys;
  pfc_handler dut (.clk_sys(clk_sys), .rst_n(rst_n), .char_valid(char_valid),
    .char_data(char_data), .accept_req(accept_req), .paper_kind_select(paper_kind_select),
    .paper_step(paper_step), .tof_mark(tof_mark), .print_done(print_done),
    .paper_move(paper_move), .print_run(print_run), .toner_pump(toner_pump),
    .char_store(char_store), .char_code(char_code), .column(column),
    .buffer_clear(buffer_clear));
  pfc_host_model host (.clk_sys(clk_sys), .rst_n(rst_n), .accept_req(accept_req),
    .char_valid(char_valid), .char_data(char_data));
  // ******
  // Paper drive and print engine
  // ******
  // Step every other cycle while moving; done pulse six cycles into a print
  always @(posedge clk_sys)
  begin
    paper_step <= paper_move && !paper_step;
    // A step landing after paper_move fell is no travel: the drive has stopped
    if (paper_step && paper_move) steps <= steps + 1;
    tof_mark <= paper_step && paper_move && (steps + 1 == tof_at);
    if (tof_mark) pump_tof <= toner_pump;
    pr_cnt <= print_run ? pr_cnt + 1 : 0;
    print_done <= print_run && (pr_cnt == 5);
    pr_q <= print_run;
    if (print_run && !pr_q) prints <= prints + 1;
    if (char_store) last_code <= char_code;
  end
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check
  task automatic conclude();
    $display("Checks %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // Wait, bounded, until the device is idle and accepting again
  task automatic settle();
    int n;
    n = 0;
    repeat (8) @(posedge clk_sys);
    while (!(accept_req === 1'b1 && paper_move === 1'b0) && n < 4000)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 4000)
    begin
      failures++;
      conclude();
    end
  endtask : settle
  task automatic put(input logic [6:0] c);
    bit ok;
    host.send(c, ok);
    if (!ok)
    begin
      failures++;
      conclude();
    end
  endtask : put
  // Random printable characters
  task automatic text(input int n);
    repeat (n)
    begin
      last_sent = 7'h20 + 7'($urandom_range(94, 0));
      put(last_sent);
    end
    settle();
    check("code", 16'(last_sent), 16'(last_code));
  endtask : text
  // Format code; tof_n steps on, the mark is pulsed
  task automatic code(input logic [6:0] c, input int tof_n);
    p0 = prints;
    s0 = steps;
    tof_at = steps + tof_n;
    put(c);
    settle();
  endtask : code
  initial
  begin
    void'($urandom(40));
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    text(5);
    check("column", 16'h0005, 16'(column));
    code(pfc_pkg::CODE_CR, 0);
    check("prints", 16'h0001, 16'(prints - p0));
    check("steps", pfc_pkg::STEPS_PER_LINE, 16'(steps - s0));
    check("column", 16'h0000, 16'(column));
    code(pfc_pkg::CODE_LF, 0);
    check("prints", 16'h0000, 16'(prints - p0));
    text(3);
    code(pfc_pkg::CODE_LF, 0);
    check("steps", pfc_pkg::STEPS_PER_LINE, 16'(steps - s0));
    check("prints", 16'h0001, 16'(prints - p0));
    code(pfc_pkg::CODE_CR, 0);
    check("steps", 16'h0000, 16'(steps - s0));
    text(pfc_pkg::LINE_CHARS);
    check("column", 16'h0000, 16'(column));
    code(pfc_pkg::CODE_CR, 0);
    check("steps", 16'h0000, 16'(steps - s0));
    code(pfc_pkg::CODE_LF, 0);
    check("steps", 16'h0000, 16'(steps - s0));
    text(pfc_pkg::LINE_CHARS);
    code(pfc_pkg::CODE_LF, 0);
    check("steps", 16'h0000, 16'(steps - s0));
    text(4);
    code(pfc_pkg::CODE_FF, 100);
    check("prints", 16'h0001, 16'(prints - p0));
    check("pump", 16'h0001, 16'(pump_tof));
    text(4);
    code(pfc_pkg::CODE_FF, 900);
    check("pump", 16'h0000, 16'(pump_tof));
    check("prints", 16'h0001, 16'(prints - p0));
    text(4);
    code(pfc_pkg::CODE_EOT, 1000);
    check("pump", 16'h0000, 16'(pump_tof));
    paper_kind_select <= 1'b1;
    text(2);
    code(pfc_pkg::CODE_EOT, 50);
    check("steps", 16'(pfc_pkg::STEPS_PER_LINE + pfc_pkg::EOT_STEPS), 16'(steps - s0));
    check("pump", 16'h0000, 16'(toner_pump));
    code(pfc_pkg::CODE_FF, 50);
    check("steps", pfc_pkg::FF_ROLL_STEPS, 16'(steps - s0));
    conclude();
  end
endmodule : test_print_format_code_handler
`default_nettype wire
